/* design/i2c_stop_map.vh */
// register map, field positions and reset values of the stop/collision block
//
// Function
// R01 - A stop drives data low and releases the clock once data reads low.
// R02 - With clock read high, the counter loads reload bits 6:0, runs to zero.
// R03 - Data read low at counter expiry after data release is a collision.
// R04 - Clock low after its release but before data release is a collision.
// R05 - A rival pulling data or clock low during our stop wins; we back off.
// R06 - Slave mode makes control two bits 5:1 mask bits; bits 7:6 keep role.
// R07 - Second-instance flags exist on the largest package only, else read 0.
// R08 - A collision sets the collision flag and returns the port to idle.
// R09 - A collision aborts the stop, frees both lines, clears the request.
// R10 - Data frees a period after clock high, stop seen, a period later done.
`ifndef I2C_STOP_MAP_VH
`define I2C_STOP_MAP_VH

// ----------------------------------------------------------------------
// register offsets on the plain register port
// ----------------------------------------------------------------------
`define ADDR_RATE_RELOAD  3'h0
`define ADDR_CONTROL_ONE  3'h1
`define ADDR_CONTROL_TWO  3'h2
`define ADDR_PORT_STATUS  3'h3
`define ADDR_SHIFT_BUFFER 3'h4
`define ADDR_PORT_FLAGS   3'h5

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define CTL1_WRITE_COLL   7
`define CTL1_ENABLE       5
`define CTL1_MODE_HI      3
`define CTL1_MODE_LO      0
`define MODE_MASTER       4'h8
`define CTL2_GEN_CALL     7
`define CTL2_ACK_STATUS   6
`define CTL2_MASK_HI      5
`define CTL2_MASK_LO      1
`define CTL2_STOP_REQ     2
`define STAT_STOP_SEEN    4
`define FLAG_PORT         0
`define FLAG_COLLISION    1
`define RELOAD_HI         6

// ----------------------------------------------------------------------
// timing counts
// ----------------------------------------------------------------------
`define SETTLE_CYCLES     2'h1

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define RST_BYTE          8'h00
`define RST_COUNT         7'h00
`define RST_SETTLE        2'h0

`endif

/* design/i2c_master_stop_collision.v */
// stop sequence and bus collision logic of a multi-master serial port
//
// The register addresses and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/10ps
`include "i2c_stop_map.vh"

module i2c_master_stop_collision #(
  parameter INSTANCE_TWO  = 0,
  parameter LARGE_PACKAGE = 1
) (
  input  wire       i_core_clk,
  input  wire       i_resetn,
  input  wire [2:0] i_addr,
  input  wire [7:0] i_wdata,
  input  wire       i_wr,
  input  wire       i_rd,
  output reg  [7:0] o_rdata,
  input  wire       i_serial_clock_pin,
  output reg        o_serial_clock_out,
  output reg        o_serial_clock_oe,
  input  wire       i_serial_data_pin,
  output reg        o_serial_data_out,
  output reg        o_serial_data_oe,
  output reg        o_collision_flag
);

  // ----------------------------------------------------------------------
  // state codes
  // ----------------------------------------------------------------------
  localparam [2:0] ST_IDLE     = 3'h0;
  localparam [2:0] ST_DATA_LOW = 3'h1;
  localparam [2:0] ST_CLK_REL  = 3'h2;
  localparam [2:0] ST_CLK_HIGH = 3'h3;
  localparam [2:0] ST_DATA_REL = 3'h4;
  localparam [2:0] ST_FINISH   = 3'h5;

  // the second instance has its flags only on the largest package
  localparam [0:0] FLAGS_PRESENT = (INSTANCE_TWO == 0) ||
                                   (LARGE_PACKAGE != 0);

  // ----------------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------------
  reg [7:0] rate_reload_reg;
  reg [7:0] control_one_reg;
  reg [7:0] control_two_reg;
  reg [7:0] shift_buffer_reg;
  reg       stop_seen_reg;
  reg       port_flag_reg;
  reg       coll_flag_reg;
  reg [6:0] bit_rate_counter_reg;
  reg [2:0] state_reg;
  reg       scl_meta_reg;
  reg       scl_sync_reg;
  reg       sda_meta_reg;
  reg       sda_sync_reg;
  reg       sda_prev_reg;
  reg       clock_oe_prev_reg;
  reg       data_oe_prev_reg;
  reg [1:0] settle_reg;

  wire       enabled     = control_one_reg[`CTL1_ENABLE];
  wire [3:0] mode        = control_one_reg[`CTL1_MODE_HI:`CTL1_MODE_LO];
  wire       master_mode = enabled && (mode == `MODE_MASTER);
  wire       counter_zero = (bit_rate_counter_reg == `RST_COUNT);
  wire       in_stop     = (state_reg != ST_IDLE);
  wire       wr_ctl1     = i_wr && (i_addr == `ADDR_CONTROL_ONE);
  wire       wr_ctl2     = i_wr && (i_addr == `ADDR_CONTROL_TWO);
  wire       wr_flags    = i_wr && (i_addr == `ADDR_PORT_FLAGS);
  wire       wr_buffer   = i_wr && (i_addr == `ADDR_SHIFT_BUFFER);
  wire       drive_changed = (o_serial_clock_oe != clock_oe_prev_reg) ||
                             (o_serial_data_oe != data_oe_prev_reg);
  wire       lines_settled = !drive_changed &&
                             (settle_reg == `RST_SETTLE);
  wire [7:0] status_view;
  wire [7:0] flags_view;

  assign status_view = {3'h0, stop_seen_reg, 4'h0};
  assign flags_view  = FLAGS_PRESENT ? {6'h00, coll_flag_reg, port_flag_reg}
                                     : 8'h00;   // R07

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  // the first stage is read only by the second; sda_prev is fed from the
  // second stage so edge detection never looks at a metastable value
  always @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      scl_meta_reg <= 1'b1;
      scl_sync_reg <= 1'b1;
      sda_meta_reg <= 1'b1;
      sda_sync_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      scl_meta_reg <= i_serial_clock_pin;
      scl_sync_reg <= scl_meta_reg;
      sda_meta_reg <= i_serial_data_pin;
      sda_sync_reg <= sda_meta_reg;
      sda_prev_reg <= sda_sync_reg;
    end
  end

  // ----------------------------------------------------------------------
  // line settle timer
  // ----------------------------------------------------------------------
  // the synced pins lag the bus by two flops, so right after the block
  // changes a drive they still show the old levels; the phase checks
  // hold off until the new level has reached the second flop, which
  // costs up to two cycles at the shortest counter periods
  always @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      clock_oe_prev_reg <= 1'b0;
      data_oe_prev_reg  <= 1'b0;
      settle_reg        <= `RST_SETTLE;
    end else begin
      clock_oe_prev_reg <= o_serial_clock_oe;
      data_oe_prev_reg  <= o_serial_data_oe;
      if (drive_changed) begin
        settle_reg <= `SETTLE_CYCLES;
      end else if (settle_reg != `RST_SETTLE) begin
        settle_reg <= settle_reg - 2'h1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------------
  always @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rdata <= `RST_BYTE;
    end else if (i_rd) begin
      case (i_addr)
        `ADDR_RATE_RELOAD:  o_rdata <= rate_reload_reg;
        `ADDR_CONTROL_ONE:  o_rdata <= control_one_reg;
        `ADDR_CONTROL_TWO:  o_rdata <= control_two_reg;
        `ADDR_PORT_STATUS:  o_rdata <= status_view;
        `ADDR_SHIFT_BUFFER: o_rdata <= shift_buffer_reg;
        `ADDR_PORT_FLAGS:   o_rdata <= flags_view;
        default:            o_rdata <= `RST_BYTE;
      endcase
    end else begin
      o_rdata <= `RST_BYTE;
    end
  end

  // ----------------------------------------------------------------------
  // registers, stop sequencer and collision detection
  // ----------------------------------------------------------------------
  // later assignments in this block override earlier ones, so hardware
  // sets placed after the software writes win over a same-cycle clear
  always @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rate_reload_reg      <= `RST_BYTE;
      control_one_reg      <= `RST_BYTE;
      control_two_reg      <= `RST_BYTE;
      shift_buffer_reg     <= `RST_BYTE;
      stop_seen_reg        <= 1'b0;
      port_flag_reg        <= 1'b0;
      coll_flag_reg        <= 1'b0;
      bit_rate_counter_reg <= `RST_COUNT;
      state_reg            <= ST_IDLE;
      o_serial_clock_out   <= 1'b0;
      o_serial_clock_oe    <= 1'b0;
      o_serial_data_out    <= 1'b0;
      o_serial_data_oe     <= 1'b0;
      o_collision_flag     <= 1'b0;
    end else begin
      // software writes
      if (i_wr && (i_addr == `ADDR_RATE_RELOAD)) begin
        rate_reload_reg <= i_wdata;
      end
      if (wr_ctl1) begin
        control_one_reg <= i_wdata;
      end
      if (wr_buffer) begin
        // a buffer write during a stop is refused and flagged
        if (in_stop) begin
          control_one_reg[`CTL1_WRITE_COLL] <= 1'b1;
        end else begin
          shift_buffer_reg <= i_wdata;
        end
      end
      if (wr_ctl2) begin
        control_two_reg[`CTL2_GEN_CALL] <= i_wdata[`CTL2_GEN_CALL];
        control_two_reg[0] <= i_wdata[0];
        if (!master_mode) begin
          // slave mode: these bits are the address mask
          control_two_reg[`CTL2_MASK_HI:`CTL2_MASK_LO] <=
            i_wdata[`CTL2_MASK_HI:`CTL2_MASK_LO];   // R06
        end else if (!in_stop) begin
          control_two_reg[`CTL2_MASK_HI:`CTL2_MASK_LO] <=
            i_wdata[`CTL2_MASK_HI:`CTL2_MASK_LO];
        end
      end
      if (wr_flags) begin
        port_flag_reg <= i_wdata[`FLAG_PORT];
        coll_flag_reg <= i_wdata[`FLAG_COLLISION];
      end

      // bus monitor: stop seen on data rising with clock high
      if (!enabled) begin
        stop_seen_reg <= 1'b0;
      end else if (scl_sync_reg && sda_sync_reg && !sda_prev_reg) begin
        stop_seen_reg <= 1'b1;   // R10
      end else if (scl_sync_reg && !sda_sync_reg && sda_prev_reg) begin
        stop_seen_reg <= 1'b0;
      end

      if (!counter_zero) begin
        bit_rate_counter_reg <= bit_rate_counter_reg - 7'h01;
      end

      // phases of a stop: data held low, clock released, clock seen high,
      // data released after one counter period, data checked after a
      // second period, request cleared after a third; both collision
      // exits land in idle with both lines released
      case (state_reg)
        ST_IDLE: begin
          o_serial_clock_oe <= 1'b0;
          o_serial_data_oe  <= 1'b0;
          // slave mode or a disabled port never starts a stop
          if (master_mode && wr_ctl2 && i_wdata[`CTL2_STOP_REQ]) begin   // R06
            control_two_reg[`CTL2_STOP_REQ] <= 1'b1;
            // clock is still held low after the last acknowledge
            o_serial_clock_oe <= 1'b1;
            o_serial_data_oe  <= 1'b1;   // R01
            state_reg         <= ST_DATA_LOW;
          end
        end
        ST_DATA_LOW: begin
          if (lines_settled && !sda_sync_reg) begin
            o_serial_clock_oe <= 1'b0;   // R01
            state_reg         <= ST_CLK_REL;
          end
        end
        ST_CLK_REL: begin
          // waiting here lets a slave stretch the clock
          if (lines_settled && scl_sync_reg) begin
            bit_rate_counter_reg <= rate_reload_reg[`RELOAD_HI:0];   // R02
            state_reg            <= ST_CLK_HIGH;
          end
        end
        ST_CLK_HIGH: begin
          if (!scl_sync_reg) begin
            // another master pulled the clock low first and wins
            control_two_reg[`CTL2_STOP_REQ] <= 1'b0;   // R09
            o_serial_data_oe  <= 1'b0;   // R09
            coll_flag_reg     <= FLAGS_PRESENT;   // R04
            state_reg         <= ST_IDLE;   // R05
          end else if (counter_zero) begin
            // clock has stood high for one period: let data rise
            o_serial_data_oe     <= 1'b0;   // R10
            bit_rate_counter_reg <= rate_reload_reg[`RELOAD_HI:0];
            state_reg            <= ST_DATA_REL;
          end
        end
        ST_DATA_REL: begin
          if (counter_zero && lines_settled) begin
            if (!sda_sync_reg) begin
              // another master is driving a zero on data
              control_two_reg[`CTL2_STOP_REQ] <= 1'b0;   // R09
              coll_flag_reg <= FLAGS_PRESENT;   // R03
              state_reg     <= ST_IDLE;   // R08
            end else begin
              // the bus monitor may already have set this
              if (scl_sync_reg) begin
                stop_seen_reg <= 1'b1;   // R10
              end
              bit_rate_counter_reg <= rate_reload_reg[`RELOAD_HI:0];
              state_reg            <= ST_FINISH;
            end
          end
        end
        ST_FINISH: begin
          if (counter_zero) begin
            control_two_reg[`CTL2_STOP_REQ] <= 1'b0;   // R10
            port_flag_reg <= FLAGS_PRESENT;   // R10
            state_reg     <= ST_IDLE;
          end
        end
        default: begin
          o_serial_clock_oe <= 1'b0;
          o_serial_data_oe  <= 1'b0;
          state_reg         <= ST_IDLE;
        end
      endcase

      // disabling the port abandons any sequence at once
      if (!enabled && in_stop) begin
        o_serial_clock_oe <= 1'b0;
        o_serial_data_oe  <= 1'b0;
        control_two_reg[`CTL2_STOP_REQ] <= 1'b0;
        stop_seen_reg <= 1'b0;
        state_reg <= ST_IDLE;
      end

      // open-drain pins only ever pull low; the enables carry the level
      o_serial_clock_out <= 1'b0;
      o_serial_data_out  <= 1'b0;
      o_collision_flag <= coll_flag_reg;
    end
  end

endmodule // i2c_master_stop_collision

/* testbench/stop_coll_properties.sv */
// port assertions of the stop and collision block
`timescale 1ns/10ps
module stop_coll_properties (
  input wire       i_core_clk,
  input wire       i_resetn,
  input wire [2:0] i_addr,
  input wire       i_wr,
  input wire       i_rd,
  input wire [7:0] o_rdata,
  input wire       i_serial_clock_pin,
  input wire       o_serial_clock_oe,
  input wire       i_serial_data_pin,
  input wire       o_serial_data_oe,
  input wire       o_collision_flag
);
  logic [7:0] low_cnt;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);
  // cycles of released data reading low; 127 counts plus sync must suffice
  always @(posedge i_core_clk or negedge i_resetn)
    if (!i_resetn) low_cnt <= 8'h00;
    else if (!o_serial_data_oe && !o_serial_clock_oe && !i_serial_data_pin
             && !o_collision_flag && low_cnt != 8'hff)
      low_cnt <= low_cnt + 8'h01;
    else low_cnt <= 8'h00;
  property p_data_first; $rose(o_serial_clock_oe) |-> o_serial_data_oe;
  endproperty
  a_data_first: assert property (p_data_first)
    else $error("clock pulled without data");
  property p_clk_release;
    $fell(o_serial_clock_oe) && o_serial_data_oe
      |-> !$past(i_serial_data_pin, 2);
  endproperty
  a_clk_release: assert property (p_clk_release)
    else $error("clock released before data read low");
  property p_data_release;
    $fell(o_serial_data_oe) |-> !o_serial_clock_oe
      && !$past(o_serial_clock_oe, 3);
  endproperty
  a_data_release: assert property (p_data_release)
    else $error("data released too early");
  property p_data_low; low_cnt < 8'h8c; endproperty
  a_data_low: assert property (p_data_low)
    else $error("data low after expiry without collision");
  property p_clk_drop;
    (!o_serial_clock_oe && o_serial_data_oe && i_serial_clock_pin) ##1
      (!o_serial_clock_oe && o_serial_data_oe && !i_serial_clock_pin)[*3]
      |-> ##[0:4] o_collision_flag;
  endproperty
  a_clk_drop: assert property (p_clk_drop)
    else $error("clock drop missed");
  property p_coll_idle;
    $rose(o_collision_flag) |-> !o_serial_clock_oe && !o_serial_data_oe;
  endproperty
  a_coll_idle: assert property (p_coll_idle)
    else $error("lines held after collision");
  property p_flag_clear;
    $fell(o_collision_flag) |-> $past(i_wr, 2) && $past(i_addr, 2) == 3'h5;
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("collision flag lost");
  property p_rdata_idle; !$past(i_rd) |-> o_rdata == 8'h00; endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data outside read slot");
endmodule // stop_coll_properties

/* testbench/bus_party_model.sv */
// other bus parties: pull-ups, a stretching slave and a rival master
`timescale 1ns/10ps
module bus_party_model (
  input  wire  i_clock_oe,
  input  wire  i_data_oe,
  input  wire  i_stretch,
  input  wire  i_run_clk,
  input  wire  i_hold_data,
  output logic o_clock_pin,
  output logic o_data_pin
);
  logic rival_clk;
  // rival clock, 800 ns period, parked high outside its frames
  initial begin
    rival_clk = 1'b1;
    #137;
    forever #400 rival_clk = i_run_clk ? ~rival_clk : 1'b1;
  end
  // wired-and with pull-ups: a released line reads high
  assign o_clock_pin = !(i_clock_oe || i_stretch || !rival_clk);
  assign o_data_pin  = !(i_data_oe || i_hold_data);
endmodule // bus_party_model

/* testbench/tb_top.sv */
// self-checking bench of the stop and collision block
`timescale 1ns/10ps
module tb_top;
  logic       i_core_clk, i_resetn, i_wr, i_rd, stretch, run_clk, hold;
  logic [2:0] i_addr;
  logic [7:0] i_wdata, rnd;
  logic [7:0] mdl [8];
  wire  [7:0] o_rdata;
  wire        ck_oe, dt_oe, ck_pin, dt_pin, coll, ck_out, dt_out;
  int         n_fail, cmp_count, cyc;
  i2c_master_stop_collision i2c_master_stop_collision_i (
    .i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_serial_clock_pin(ck_pin), .o_serial_clock_out(ck_out),
    .o_serial_clock_oe(ck_oe), .i_serial_data_pin(dt_pin),
    .o_serial_data_out(dt_out), .o_serial_data_oe(dt_oe),
    .o_collision_flag(coll));
  bus_party_model bus_party_model_i (.i_clock_oe(ck_oe), .i_data_oe(dt_oe),
    .i_stretch(stretch), .i_run_clk(run_clk), .i_hold_data(hold),
    .o_clock_pin(ck_pin), .o_data_pin(dt_pin));
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_rng(input int v, input int lo, input int hi);
    cmp_count++;
    if (v < lo || v > hi) begin
      n_fail++;
      $display("[FAIL] %0t count %0d outside %0d..%0d", $time, v, lo, hi);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
    if (a == 3'h2) mdl[2] = d & 8'hbf;
    else if (a == 3'h5) mdl[5] = d & 8'h03;
    else if (a != 3'h3 && a < 3'h6) mdl[a] = d;
  endtask
  task automatic rd_chk(input logic [2:0] a);
    @(posedge i_core_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    #1 chk8(o_rdata, mdl[a]);
  endtask
  task automatic wait_lvl(input bit clk_side, input logic lvl);
    cyc = 0;
    while ((clk_side ? ck_oe : dt_oe) !== lvl && cyc < 1000) begin
      @(posedge i_core_clk);
      #1 cyc++;
    end
    if (cyc == 1000) begin
      n_fail++;
      $display("[FAIL] %0t enable never reached %0b", $time, lvl);
    end
  endtask
  task automatic start_stop(input int cnt, input int hld);
    stretch <= hld != 0;
    wr(3'h0, cnt[7:0]);
    wr(3'h2, 8'h04);
    wait_lvl(1, 1'b1);
    wait_lvl(1, 1'b0);
    chk8({7'h00, dt_oe}, 8'h01);
    repeat (hld) @(posedge i_core_clk);
    stretch <= 1'b0;
  endtask
  task automatic normal_stop(input int cnt, input int hld);
    start_stop(cnt, hld);
    wait_lvl(0, 1'b0);
    chk_rng(cyc, cnt + 2, cnt + 8);
    repeat (2 * cnt + 12) @(posedge i_core_clk);
    mdl[2] = mdl[2] & 8'hfb;
    mdl[3] = 8'h10;
    mdl[5] = mdl[5] | 8'h01;
    rd_chk(3'h3);
    rd_chk(3'h2);
    rd_chk(3'h5);
  endtask
  task automatic coll_check();
    mdl[2] = mdl[2] & 8'hfb;
    mdl[5] = mdl[5] | 8'h02;
    chk8({7'h00, coll}, 8'h01);
    rd_chk(3'h5);
    rd_chk(3'h2);
    chk8({6'h00, ck_oe, dt_oe}, 8'h00);
    chk8({6'h00, ck_out, dt_out}, 8'h00);
    wr(3'h5, 8'h00);
    rd_chk(3'h5);
    chk8({7'h00, coll}, 8'h00);
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    i_core_clk = 1'b0;
    forever #50 i_core_clk = ~i_core_clk;
  end
  // whole run is under a thousand cycles; allow twenty thousand
  initial begin
    #2000000;
    n_fail++;
    report_and_stop();
  end
  initial begin
    {i_resetn, i_wr, i_rd, stretch, run_clk, hold} = 6'h00;
    i_addr = 3'h0;
    i_wdata = 8'h00;
    mdl = '{default: 8'h00};
    rnd = 8'($urandom(32'h710f2e1e));
    repeat (10) @(posedge i_core_clk);
    i_resetn <= 1'b1;
    for (int a = 0; a < 8; a++) rd_chk(a[2:0]);
    wr(3'h0, rnd);
    wr(3'h3, 8'hff);
    wr(3'h7, 8'hff);
    for (int a = 0; a < 8; a++) rd_chk(a[2:0]);
    $display("register test done");
    wr(3'h1, 8'h20);
    wr(3'h2, 8'hfe);
    rd_chk(3'h2);
    repeat (4) @(posedge i_core_clk);
    chk8({6'h00, ck_oe, dt_oe}, 8'h00);
    $display("slave mask test done");
    wr(3'h1, 8'h28);
    normal_stop($urandom % 128, 12);
    normal_stop(0, 0);
    $display("normal stop test done");
    start_stop(20, 0);
    wait_lvl(0, 1'b0);
    hold <= 1'b1;
    repeat (40) @(posedge i_core_clk);
    hold <= 1'b0;
    coll_check();
    $display("data collision test done");
    start_stop(60, 0);
    repeat (8) @(posedge i_core_clk);
    run_clk <= 1'b1;
    repeat (30) @(posedge i_core_clk);
    run_clk <= 1'b0;
    coll_check();
    $display("clock collision test done");
    report_and_stop();
  end
endmodule // tb_top
bind i2c_master_stop_collision stop_coll_properties stop_coll_properties_i (
  .i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_addr(i_addr),
  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .i_serial_clock_pin(i_serial_clock_pin),
  .o_serial_clock_oe(o_serial_clock_oe),
  .i_serial_data_pin(i_serial_data_pin),
  .o_serial_data_oe(o_serial_data_oe),
  .o_collision_flag(o_collision_flag));
